/* File: rtl/hpi_pkg.sv */
/*
 Shared constants and types of the host port integration shell: register map,
 field positions, status bit layout, descriptor offsets, timing and carriers.
 Assumes a single 40 MHz system clock and a word-aligned register port.
*/
package hpi_pkg;

    // Register offsets
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_HUB = 8'h0C;
    localparam logic [7:0] REG_DESC = 8'h10;
    localparam logic [7:0] REG_START = 8'h14;

    // Control register fields
    localparam int CTL_DEV_EN = 0;
    localparam int CTL_SRC_SEL = 1;
    localparam int CTL_FS_EN = 2;
    localparam int CTL_OC_EN = 3;
    localparam int CTL_DIV_LSB = 4;
    localparam int DIV_W = 4;
    localparam logic [3:0] DIV_RESET = 4'h0;

    // Status and mask bit positions
    localparam int EVENTS = 5;
    localparam int ST_UNRECOV = 0;
    localparam int ST_CONN_A = 1;
    localparam int ST_CONN_B = 2;
    localparam int ST_XCVR_LOST = 3;
    localparam int ST_DONE = 4;

    // Root hub register fields
    localparam logic [7:0] ROOT_PORTS = 8'h02;
    localparam int HUB_CONN_LSB = 8;
    localparam int HUB_SPEED_A_LSB = 12;
    localparam int HUB_SPEED_B_LSB = 14;
    localparam int HUB_DEV_SEL = 16;
    localparam int HUB_XCVR_ALIVE = 17;
    localparam int HUB_OC_EN = 18;

    // Port speed codes
    localparam logic [1:0] SPEED_NONE = 2'h0;
    localparam logic [1:0] SPEED_LOW = 2'h1;
    localparam logic [1:0] SPEED_FULL = 2'h2;
    localparam logic [1:0] SPEED_HIGH = 2'h3;

    // Descriptor layout, byte offsets from the descriptor base
    localparam logic [31:0] TD_OFFSET = 32'h0000_0004;
    localparam logic [31:0] RETIRE_OFFSET = 32'h0000_0008;

    // Full-speed clock chain: 12 MHz is the 48 MHz tick divided by four
    localparam int FS12_DIVIDE = 4;

    // Transceiver clock watchdog
    localparam int CLOCK_NS = 25;
    localparam int XCVR_WATCH_NS = 1000;
    localparam int XCVR_WATCH_CYC = XCVR_WATCH_NS / CLOCK_NS;

    typedef enum logic [4:0] {
        DMA_IDLE = 5'h01,
        DMA_FETCH_ED = 5'h02,
        DMA_FETCH_TD = 5'h04,
        DMA_MOVE = 5'h08,
        DMA_RETIRE = 5'h10
    } hpi_dma_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } hpi_reg_req_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } hpi_mem_req_s;

    typedef struct packed {
        logic abort;
        logic ack;
        logic [31:0] rdata;
    } hpi_mem_rsp_s;

    typedef struct packed {
        logic dplus;
        logic dminus;
        logic hs_chirp;
    } hpi_line_s;

endpackage

/* File: rtl/hpi_sync.sv */
/*
 Two-stage synchroniser for a bundle of unrelated levels.
 Assumes each bit is an independent level or toggle; no bus coherence.
*/
`timescale 1ns/10ps
`default_nettype none
module hpi_sync #(
    parameter int WIDTH = 9
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } hpi_sync_s;

    hpi_sync_s s_reg;
    hpi_sync_s s_next;

    // Refused at elaboration, before any logic exists
    if (WIDTH < 1)
    begin
        $error("hpi_sync needs at least one bit");
    end

    // The first stage feeds only the second stage
    always_comb
    begin
        s_next.meta = async_in;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign sync_out = s_reg.stable;
endmodule
`default_nettype wire

/* File: rtl/hpi_core.sv */
/*
 Host port integration shell: register port, sticky interrupts, descriptor
 bus master, root hub attach detection, transceiver routing and the
 full-speed clock enables. Assumes one 40 MHz clock; PLL and transceiver
 clocks arrive as toggles from their own domains; memory answers on this clock.
*/
// How it works
// - Port A belongs to the host on the first transceiver from the first clock after reset.
// - Setting the device enable hands transceiver two to the device controller.
// - Software reads and writes host registers through the register slave port.
// - Bus master fetches descriptors, moves data and writes retire status.
// - Aborted or misaligned master access sets the unrecoverable error flag.
// - Root hub has two ports; the count reads from the hub register.
// - Attach on a port is detected by hardware and flagged; port B only while the device enable is clear.
// - Transceiver returns a 30 MHz clock; its presence is watched.
// - 12 MHz enable is the 48 MHz enable divided by four.
// - Full-speed source selects between utmi and main PLL.
// - One interrupt line; software sets up the interrupt controller first.
// - Port lines are driven only by transceivers under host control.
// - Over-current protection can be enabled but has no input pads.
`timescale 1ns/10ps
`default_nettype none
module hpi_core #(
    parameter int WATCH_CYCLES = hpi_pkg::XCVR_WATCH_CYC,
    parameter int WATCH_W = 6
) (
    input wire logic clock,
    input wire logic reset,
    input wire hpi_pkg::hpi_reg_req_s reg_req,
    output logic [31:0] reg_rdata,
    output logic irq,
    output hpi_pkg::hpi_mem_req_s mem_req,
    input wire hpi_pkg::hpi_mem_rsp_s mem_rsp,
    input wire logic utmi_pll_clock,
    input wire logic main_pll_clock,
    input wire logic xcvr_clock_toggle,
    input wire hpi_pkg::hpi_line_s line_a,
    input wire hpi_pkg::hpi_line_s line_b,
    output logic fullspeed_clk_48,
    output logic fullspeed_clk_12,
    output logic port_a_host_sel,
    output logic xcvr_b_device_sel,
    output logic port_a_oe_n,
    output logic port_b_oe_n
);
    typedef struct packed {
        logic dev_en;
        logic src_sel;
        logic fs_en;
        logic oc_en;
        logic [hpi_pkg::DIV_W-1:0] div;
        logic [hpi_pkg::EVENTS-1:0] status;
        logic [hpi_pkg::EVENTS-1:0] mask;
        logic irq;
        logic [31:0] rdata;
        logic [31:0] desc;
        hpi_pkg::hpi_dma_e dma;
        hpi_pkg::hpi_mem_req_s mem;
        logic [1:0] conn;
        logic [1:0] speed_a;
        logic [1:0] speed_b;
        logic [2:0] tog_prev;
        logic [hpi_pkg::DIV_W-1:0] div_cnt;
        logic [1:0] quarter;
        logic tick48;
        logic tick12;
        logic [WATCH_W-1:0] watch;
        logic alive;
        logic a_sel;
        logic dev_sel;
        logic [1:0] oe_n;
    } hpi_core_s;

    hpi_core_s s_reg;
    hpi_core_s s_next;
    logic [8:0] sync_q;
    hpi_pkg::hpi_line_s la;
    hpi_pkg::hpi_line_s lb;

    if (WATCH_CYCLES < 2 || WATCH_CYCLES >= (1 << WATCH_W))
    begin
        $error("hpi_core WATCH_CYCLES does not fit WATCH_W");
    end

    function automatic logic [1:0] speed_of(input hpi_pkg::hpi_line_s l);
        if (l.hs_chirp)
            speed_of = hpi_pkg::SPEED_HIGH;
        else if (l.dplus)
            speed_of = hpi_pkg::SPEED_FULL;
        else if (l.dminus)
            speed_of = hpi_pkg::SPEED_LOW;
        else
            speed_of = hpi_pkg::SPEED_NONE;
    endfunction

    function automatic logic is_reg(input hpi_pkg::hpi_reg_req_s r, input logic [7:0] a);
        is_reg = (r.addr == a);
    endfunction

    // Toggles and line states from foreign domains pass two flops
    hpi_sync #(
        .WIDTH(9)
    ) u_sync (
        .clock(clock),
        .reset(reset),
        .async_in({xcvr_clock_toggle, main_pll_clock, utmi_pll_clock, line_b, line_a}),
        .sync_out(sync_q)
    );

    assign la = sync_q[2:0];
    assign lb = sync_q[5:3];

    always_comb
    begin
        logic [2:0] edges;
        logic src_edge;
        logic [hpi_pkg::EVENTS-1:0] ev;
        logic [hpi_pkg::EVENTS-1:0] clr;
        logic abort;
        edges = sync_q[8:6] ^ s_reg.tog_prev;
        src_edge = 1'b0;
        ev = '0;
        clr = '0;
        abort = 1'b0;
        s_next = s_reg;
        s_next.tog_prev = sync_q[8:6];
        s_next.rdata = '0;

        // Register writes
        if (reg_req.wr)
        begin
            if (is_reg(reg_req, hpi_pkg::REG_CONTROL))
            begin
                s_next.dev_en = reg_req.wdata[hpi_pkg::CTL_DEV_EN];
                s_next.src_sel = reg_req.wdata[hpi_pkg::CTL_SRC_SEL];
                s_next.fs_en = reg_req.wdata[hpi_pkg::CTL_FS_EN];
                s_next.oc_en = reg_req.wdata[hpi_pkg::CTL_OC_EN];
                s_next.div = reg_req.wdata[hpi_pkg::CTL_DIV_LSB +: hpi_pkg::DIV_W];
            end
            if (is_reg(reg_req, hpi_pkg::REG_MASK))
                s_next.mask = reg_req.wdata[hpi_pkg::EVENTS-1:0];
            if (is_reg(reg_req, hpi_pkg::REG_DESC) && s_reg.dma == hpi_pkg::DMA_IDLE)
                s_next.desc = reg_req.wdata;
        end

        // Register reads, data in the following cycle only
        if (reg_req.rd)
        begin
            if (is_reg(reg_req, hpi_pkg::REG_CONTROL))
            begin
                s_next.rdata[hpi_pkg::CTL_DEV_EN] = s_reg.dev_en;
                s_next.rdata[hpi_pkg::CTL_SRC_SEL] = s_reg.src_sel;
                s_next.rdata[hpi_pkg::CTL_FS_EN] = s_reg.fs_en;
                s_next.rdata[hpi_pkg::CTL_OC_EN] = s_reg.oc_en;
                s_next.rdata[hpi_pkg::CTL_DIV_LSB +: hpi_pkg::DIV_W] = s_reg.div;
            end
            if (is_reg(reg_req, hpi_pkg::REG_STATUS))
            begin
                s_next.rdata[hpi_pkg::EVENTS-1:0] = s_reg.status;
                clr = '1;
            end
            if (is_reg(reg_req, hpi_pkg::REG_MASK))
                s_next.rdata[hpi_pkg::EVENTS-1:0] = s_reg.mask;
            if (is_reg(reg_req, hpi_pkg::REG_HUB))
            begin
                s_next.rdata[7:0] = hpi_pkg::ROOT_PORTS;
                s_next.rdata[hpi_pkg::HUB_CONN_LSB +: 2] = s_reg.conn;
                s_next.rdata[hpi_pkg::HUB_SPEED_A_LSB +: 2] = s_reg.speed_a;
                s_next.rdata[hpi_pkg::HUB_SPEED_B_LSB +: 2] = s_reg.speed_b;
                s_next.rdata[hpi_pkg::HUB_DEV_SEL] = s_reg.dev_sel;
                s_next.rdata[hpi_pkg::HUB_XCVR_ALIVE] = s_reg.alive;
                s_next.rdata[hpi_pkg::HUB_OC_EN] = s_reg.oc_en;
            end
            if (is_reg(reg_req, hpi_pkg::REG_DESC))
                s_next.rdata = s_reg.desc;
        end

        // Root hub attach detection without polling
        s_next.speed_a = speed_of(la);
        s_next.speed_b = s_reg.dev_en ? hpi_pkg::SPEED_NONE : speed_of(lb);
        s_next.conn[0] = (speed_of(la) != hpi_pkg::SPEED_NONE);
        s_next.conn[1] = !s_reg.dev_en && (speed_of(lb) != hpi_pkg::SPEED_NONE);
        ev[hpi_pkg::ST_CONN_A] = s_next.conn[0] ^ s_reg.conn[0];
        ev[hpi_pkg::ST_CONN_B] = s_next.conn[1] ^ s_reg.conn[1];

        // Transceiver routing; port A never leaves the host
        s_next.a_sel = 1'b1;
        s_next.dev_sel = s_next.dev_en;
        s_next.oe_n[0] = !s_next.conn[0];
        s_next.oe_n[1] = !(s_next.conn[1] && !s_next.dev_en);

        // Full-speed clock enables from the selected PLL
        src_edge = s_reg.src_sel ? edges[1] : edges[0];
        s_next.tick48 = 1'b0;
        s_next.tick12 = 1'b0;
        if (s_reg.fs_en && src_edge)
        begin
            if (s_reg.div_cnt == s_reg.div)
            begin
                s_next.div_cnt = '0;
                s_next.tick48 = 1'b1;
                s_next.quarter = s_reg.quarter + 2'd1;
                s_next.tick12 = (s_reg.quarter == 2'(hpi_pkg::FS12_DIVIDE - 1));
            end
            else
                s_next.div_cnt = s_reg.div_cnt + 1'b1;
        end

        // Transceiver 30 MHz clock watchdog
        if (edges[2])
        begin
            s_next.watch = '0;
            s_next.alive = 1'b1;
        end
        else if (s_reg.watch != WATCH_W'(WATCH_CYCLES))
            s_next.watch = s_reg.watch + 1'b1;
        else
            s_next.alive = 1'b0;
        ev[hpi_pkg::ST_XCVR_LOST] = s_reg.alive && !s_next.alive;

        // Descriptor bus master
        abort = mem_rsp.ack && mem_rsp.abort;
        if (mem_rsp.ack)
        begin
            s_next.mem.rd = 1'b0;
            s_next.mem.wr = 1'b0;
        end
        case (s_reg.dma)
            hpi_pkg::DMA_IDLE:
            begin
                if (reg_req.wr && is_reg(reg_req, hpi_pkg::REG_START) && reg_req.wdata[0])
                begin
                    if (s_reg.desc[1:0] != 2'h0)
                        ev[hpi_pkg::ST_UNRECOV] = 1'b1;
                    else
                    begin
                        s_next.mem.rd = 1'b1;
                        s_next.mem.addr = s_reg.desc;
                        s_next.dma = hpi_pkg::DMA_FETCH_ED;
                    end
                end
            end
            hpi_pkg::DMA_FETCH_ED:
            begin
                if (mem_rsp.ack && !abort)
                begin
                    s_next.mem.rd = 1'b1;
                    s_next.mem.addr = s_reg.desc + hpi_pkg::TD_OFFSET;
                    s_next.dma = hpi_pkg::DMA_FETCH_TD;
                end
            end
            hpi_pkg::DMA_FETCH_TD:
            begin
                if (mem_rsp.ack && !abort)
                begin
                    if (mem_rsp.rdata[1:0] != 2'h0)
                    begin
                        ev[hpi_pkg::ST_UNRECOV] = 1'b1;
                        s_next.dma = hpi_pkg::DMA_IDLE;
                    end
                    else
                    begin
                        s_next.mem.rd = 1'b1;
                        s_next.mem.addr = mem_rsp.rdata;
                        s_next.dma = hpi_pkg::DMA_MOVE;
                    end
                end
            end
            hpi_pkg::DMA_MOVE:
            begin
                if (mem_rsp.ack && !abort)
                begin
                    s_next.mem.wr = 1'b1;
                    s_next.mem.addr = s_reg.desc + hpi_pkg::RETIRE_OFFSET;
                    s_next.mem.wdata = mem_rsp.rdata;
                    s_next.dma = hpi_pkg::DMA_RETIRE;
                end
            end
            hpi_pkg::DMA_RETIRE:
            begin
                if (mem_rsp.ack && !abort)
                begin
                    ev[hpi_pkg::ST_DONE] = 1'b1;
                    s_next.dma = hpi_pkg::DMA_IDLE;
                end
            end
            default:
            begin
                s_next.dma = hpi_pkg::DMA_IDLE;
            end
        endcase
        // An aborted access ends the job whatever stage it was in
        if (abort && s_reg.dma != hpi_pkg::DMA_IDLE)
        begin
            ev[hpi_pkg::ST_UNRECOV] = 1'b1;
            s_next.dma = hpi_pkg::DMA_IDLE;
        end

        // Sticky status: an event in the clearing cycle survives the clear
        s_next.status = (s_reg.status & ~clr) | ev;
        s_next.irq = |(s_next.status & s_next.mask);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s_reg <= '0;
            s_reg.dma <= hpi_pkg::DMA_IDLE;
            s_reg.div <= hpi_pkg::DIV_RESET;
            s_reg.oe_n <= 2'h3;
        end
        else
            s_reg <= s_next;
    end

    assign reg_rdata = s_reg.rdata;
    assign irq = s_reg.irq;
    assign mem_req = s_reg.mem;
    assign fullspeed_clk_48 = s_reg.tick48;
    assign fullspeed_clk_12 = s_reg.tick12;
    assign port_a_host_sel = s_reg.a_sel;
    assign xcvr_b_device_sel = s_reg.dev_sel;
    assign port_a_oe_n = s_reg.oe_n[0];
    assign port_b_oe_n = s_reg.oe_n[1];

    a_port_a_fixed: assert property (@(posedge clock) disable iff (reset)
        !$past(reset) |-> port_a_host_sel) else $error("port A left host");
    a_port_b_device: assert property (@(posedge clock) disable iff (reset)
        (reg_req.wr && is_reg(reg_req, hpi_pkg::REG_CONTROL) && reg_req.wdata[hpi_pkg::CTL_DEV_EN])
        |=> xcvr_b_device_sel ##1 port_b_oe_n) else $error("port B not handed over");
    a_hub_count: assert property (@(posedge clock) disable iff (reset)
        (reg_req.rd && is_reg(reg_req, hpi_pkg::REG_HUB)) |=> reg_rdata[7:0] == 8'h02)
        else $error("bad port count");
    a_mem_aligned: assert property (@(posedge clock) disable iff (reset)
        (mem_req.rd || mem_req.wr) |-> mem_req.addr[1:0] == 2'h0) else $error("misaligned request");
    a_abort_flag: assert property (@(posedge clock) disable iff (reset)
        (mem_rsp.ack && mem_rsp.abort && s_reg.dma != hpi_pkg::DMA_IDLE)
        |=> s_reg.status[hpi_pkg::ST_UNRECOV] && s_reg.dma == hpi_pkg::DMA_IDLE) else $error("abort lost");
    a_attach_flag: assert property (@(posedge clock) disable iff (reset)
        $changed(s_reg.conn[0]) |-> s_reg.status[hpi_pkg::ST_CONN_A]) else $error("attach not flagged");
    a_fs12_ratio: assert property (@(posedge clock) disable iff (reset)
        fullspeed_clk_12 |-> fullspeed_clk_48 && s_reg.quarter == 2'h0) else $error("12 MHz out of step");
    a_fs_gated: assert property (@(posedge clock) disable iff (reset)
        !s_reg.fs_en ##1 !s_reg.fs_en |-> !fullspeed_clk_48) else $error("tick while disabled");
    a_xcvr_watch: assert property (@(posedge clock) disable iff (reset)
        (s_reg.watch == WATCH_W'(WATCH_CYCLES) && !(sync_q[8] ^ s_reg.tog_prev[2])) |=> !s_reg.alive)
        else $error("dead clock unseen");
    a_irq_level: assert property (@(posedge clock) disable iff (reset)
        irq == |(s_reg.status & s_reg.mask)) else $error("irq mismatch");
    // A settled hand-over must also have dropped the host's view of port B
    a_b_quiet: assert property (@(posedge clock) disable iff (reset)
        xcvr_b_device_sel |-> port_b_oe_n && (!$past(xcvr_b_device_sel) || !s_reg.conn[1]))
        else $error("host drives device port");

    c_job_done: cover property (@(posedge clock) disable iff (reset) s_reg.status[hpi_pkg::ST_DONE]);
    c_attach_a: cover property (@(posedge clock) disable iff (reset) $rose(s_reg.conn[0]));
    c_switch_b: cover property (@(posedge clock) disable iff (reset) $rose(xcvr_b_device_sel));
    c_tick12: cover property (@(posedge clock) disable iff (reset) fullspeed_clk_12);
endmodule
`default_nettype wire

/* File: test/hpi_mem_model.sv */
/*
 Memory model on the far side of the descriptor bus master.
 Assumes the master holds a request until ack and shares the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module hpi_mem_model (
    input wire logic clock,
    input wire logic reset,
    input wire hpi_pkg::hpi_mem_req_s mem_req,
    input wire logic [3:0] delay,
    input wire logic abort_en,
    input wire logic skew_en,
    output hpi_pkg::hpi_mem_rsp_s mem_rsp,
    output logic [31:0] last_wdata
);
    logic [3:0] wait_cnt;

    always_ff @(posedge clock)
    begin
        mem_rsp.ack <= 1'h0;
        mem_rsp.abort <= 1'h0;
        // Read data change every cycle outside ack, so a late sample shows up
        mem_rsp.rdata <= ~mem_rsp.rdata;
        if (reset)
        begin
            wait_cnt <= 4'h0;
            mem_rsp.rdata <= 32'h5555_5555;
        end
        else if ((mem_req.rd || mem_req.wr) && !mem_rsp.ack)
        begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == delay)
            begin
                wait_cnt <= 4'h0;
                mem_rsp.ack <= 1'h1;
                mem_rsp.abort <= abort_en;
                // Skew pushes a returned pointer off word alignment
                if (mem_req.rd)
                    mem_rsp.rdata <= mem_req.addr + 32'h0000_0100 + {30'h0000_0000, skew_en, 1'h0};
                else
                    last_wdata <= mem_req.wdata;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/hpi_core_tb_top.sv */
/*
 Self-checking bench for the host port integration shell.
 Assumes register reads answer one cycle later and the memory model serves the bus master.
*/
`timescale 1ns/10ps
`default_nettype none
module hpi_core_tb_top;
    localparam logic [32:0] EXP_LOG [4] = '{33'h0_0000_0040, 33'h0_0000_0044, 33'h0_0000_0144, 33'h1_0000_0048};
    logic clock, reset, irq, utmi_pll_clock, main_pll_clock, xcvr_clock_toggle, xcvr_run;
    logic fs48, fs12, host_sel_a, dev_sel_b, oe_a_n, oe_b_n, abort_en, skew_en;
    hpi_pkg::hpi_reg_req_s reg_req;
    hpi_pkg::hpi_mem_req_s mem_req;
    hpi_pkg::hpi_mem_rsp_s mem_rsp;
    hpi_pkg::hpi_line_s line_a, line_b;
    logic [3:0] delay;
    logic [31:0] reg_rdata, last_wdata, rd_val;
    logic [32:0] mem_log[$];
    int n_mismatch, compares, n48, n12;

    // Short watchdog keeps the lost-clock scenario brief
    hpi_core #(.WATCH_CYCLES(4), .WATCH_W(6)) dut (.clock(clock), .reset(reset), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .irq(irq), .mem_req(mem_req), .mem_rsp(mem_rsp),
        .utmi_pll_clock(utmi_pll_clock), .main_pll_clock(main_pll_clock),
        .xcvr_clock_toggle(xcvr_clock_toggle), .line_a(line_a), .line_b(line_b),
        .fullspeed_clk_48(fs48), .fullspeed_clk_12(fs12), .port_a_host_sel(host_sel_a),
        .xcvr_b_device_sel(dev_sel_b), .port_a_oe_n(oe_a_n), .port_b_oe_n(oe_b_n));
    hpi_mem_model mem (.clock(clock), .reset(reset), .mem_req(mem_req), .delay(delay),
        .abort_en(abort_en), .skew_en(skew_en), .mem_rsp(mem_rsp), .last_wdata(last_wdata));

    initial
    begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (mem_rsp.ack)
            mem_log.push_back({mem_req.wr, mem_req.addr});
        if (fs48)
            n48++;
        if (fs12)
            n12++;
        if (xcvr_run)
            xcvr_clock_toggle <= ~xcvr_clock_toggle;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clock);
        reg_req <= '{rd: 1'h0, wr: 1'h1, addr: addr, wdata: data};
        @(posedge clock);
        reg_req <= '0;
    endtask

    task automatic reg_rd(input logic [7:0] addr);
        @(posedge clock);
        reg_req <= '{rd: 1'h1, wr: 1'h0, addr: addr, wdata: 32'h0000_0000};
        @(posedge clock);
        reg_req <= '0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic wait_irq();
        for (int i = 0; i < 200 && irq !== 1'h1; i++)
            @(posedge clock);
        if (irq !== 1'h1)
        begin
            n_mismatch++;
            end_of_test();
        end
    endtask

    task automatic run_job(input logic [31:0] base);
        mem_log.delete();
        reg_wr(hpi_pkg::REG_DESC, base);
        reg_wr(hpi_pkg::REG_START, 32'h0000_0001);
        wait_irq();
        reg_rd(hpi_pkg::REG_STATUS);
    endtask

    // Two cycles per toggle so the two-flop synchroniser sees every edge
    task automatic toggle(input logic on_main, input int n);
        repeat (n)
        begin
            @(posedge clock);
            if (on_main)
                main_pll_clock <= ~main_pll_clock;
            else
                utmi_pll_clock <= ~utmi_pll_clock;
            @(posedge clock);
        end
        cycles(6);
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        reset = 1'h1;
        reg_req = '0;
        {utmi_pll_clock, main_pll_clock, xcvr_clock_toggle, abort_en, skew_en} = 5'h00;
        xcvr_run = 1'h1;
        line_a = '0;
        line_b = '0;
        delay = 4'h0;
        cycles(12);
        reset <= 1'h0;
        reg_rd(hpi_pkg::REG_HUB);
        check(rd_val[7:0], hpi_pkg::ROOT_PORTS);
        check(host_sel_a, 1'h1);
        reg_rd(8'h1C);
        check(rd_val, 32'h0000_0000);
        reg_wr(hpi_pkg::REG_CONTROL, 32'h0000_0098);
        reg_rd(hpi_pkg::REG_CONTROL);
        check(rd_val, 32'h0000_0098);
        reg_rd(hpi_pkg::REG_HUB);
        check(rd_val[hpi_pkg::HUB_OC_EN], 1'h1);
        check(rd_val[hpi_pkg::HUB_XCVR_ALIVE], 1'h1);
        reg_rd(hpi_pkg::REG_STATUS);
        @(posedge clock);
        line_a.dplus <= 1'h1;
        line_b.hs_chirp <= 1'h1;
        cycles(8);
        check(irq, 1'h0);
        check({oe_a_n, oe_b_n}, 2'h0);
        reg_rd(hpi_pkg::REG_HUB);
        check(rd_val[9:8], 2'h3);
        check(rd_val[15:12], {hpi_pkg::SPEED_HIGH, hpi_pkg::SPEED_FULL});
        reg_wr(hpi_pkg::REG_MASK, 32'h0000_0002);
        cycles(2);
        check(irq, 1'h1);
        reg_rd(hpi_pkg::REG_STATUS);
        check(rd_val[2:1], 2'h3);
        cycles(2);
        check(irq, 1'h0);
        reg_wr(hpi_pkg::REG_CONTROL, 32'h0000_0099);
        cycles(2);
        check({host_sel_a, dev_sel_b, oe_a_n, oe_b_n}, 4'hD);
        reg_rd(hpi_pkg::REG_HUB);
        check({rd_val[hpi_pkg::HUB_DEV_SEL], rd_val[9:8]}, 3'h5);
        @(posedge clock);
        xcvr_run <= 1'h0;
        cycles(12);
        reg_rd(hpi_pkg::REG_HUB);
        check(rd_val[hpi_pkg::HUB_XCVR_ALIVE], 1'h0);
        reg_rd(hpi_pkg::REG_STATUS);
        check(rd_val[hpi_pkg::ST_XCVR_LOST], 1'h1);
        xcvr_run <= 1'h1;
        reg_wr(hpi_pkg::REG_MASK, 32'h0000_0011);
        for (int d = 0; d < 2; d++)
        begin
            delay <= d ? 4'h0 : 4'h3;
            run_job(32'h0000_0040);
            check({rd_val[hpi_pkg::ST_DONE], rd_val[hpi_pkg::ST_UNRECOV]}, 2'h2);
            check(mem_log.size(), 4);
            foreach (EXP_LOG[i]) check(mem_log[i], EXP_LOG[i]);
            check(last_wdata, 32'h0000_0244);
        end
        abort_en <= 1'h1;
        run_job(32'h0000_0040);
        check({rd_val[hpi_pkg::ST_DONE], rd_val[hpi_pkg::ST_UNRECOV]}, 2'h1);
        check(mem_log.size(), 1);
        abort_en <= 1'h0;
        run_job(32'h0000_0042);
        check(rd_val[hpi_pkg::ST_UNRECOV], 1'h1);
        check(mem_log.size(), 0);
        skew_en <= 1'h1;
        run_job(32'h0000_0040);
        check({rd_val[hpi_pkg::ST_DONE], rd_val[hpi_pkg::ST_UNRECOV]}, 2'h1);
        check(mem_log.size(), 2);
        skew_en <= 1'h0;
        line_a <= '{dplus: 1'h0, dminus: 1'h1, hs_chirp: 1'h0};
        cycles(6);
        reg_rd(hpi_pkg::REG_HUB);
        check(rd_val[13:12], hpi_pkg::SPEED_LOW);
        reg_wr(hpi_pkg::REG_CONTROL, 32'h0000_0006);
        n48 = 0;
        n12 = 0;
        toggle(1'h1, 48);
        check(n48, 48);
        check(n12, 12);
        toggle(1'h0, 20);
        check(n48, 48);
        reg_wr(hpi_pkg::REG_CONTROL, 32'h0000_0094);
        toggle(1'h0, 100);
        check(n48, 58);
        check(n12, 14);
        end_of_test();
    end
endmodule
`default_nettype wire
